// [dv/test_travel_limit_supervisor.sv]
// Purpose: self-checking bench for the travel limit supervisor
// Assumes: warning hold shortened to HOLD cycles
// Notes: reads are checked from a queue by a monitor
module test_travel_limit_supervisor;
    timeunit 1ns;
    timeprecision 1ns;
    localparam HOLD = 50;
    localparam [31:0] M = 32'hffffffff;
    reg clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, rs = 1'b0;
    reg pwr = 1'b0, tq = 1'b0, pos = 1'b0, rf = 1'b0, rr = 1'b0;
    reg stp_in = 1'b0, tf = 1'b0, tr = 1'b0, creq = 1'b0;
    reg [3:0] adr = 4'h0;
    reg [31:0] wdat = 32'h0, v;
    reg [63:0] exp_q[$];
    reg [63:0] e;
    reg [7:0] codes[0:4] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h20};
    reg [3:0] mv[0:4] = '{4'h8, 4'h8, 4'h2, 4'h4, 4'h4};
    reg [3:0] st[0:4] = '{4'h2, 4'h2, 4'h2, 4'h1, 4'h2};
    integer err_count = 0, cmp_count = 0, seed = 29201, cyc = 0, i;
    wire [31:0] rdat;
    wire [9:0] tqo;
    wire wt, fl, rl, clr, herr, fok, rok, brk, dec, cst, zc;
    travel_limit_supervisor #(.HOLD_CYCLES(HOLD)) dut (
        .sys_clk_in(clk), .arst_n_in(rst_n), .restart_in(rs),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdat), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wt), .forward_limit_input_in(fl),
        .reverse_limit_input_in(rl), .error_clear_input_in(clr),
        .motor_power_on_in(pwr), .torque_control_in(tq),
        .position_control_in(pos), .ref_forward_in(rf),
        .ref_reverse_in(rr), .motor_stopped_in(stp_in),
        .forward_allowed_out(fok), .reverse_allowed_out(rok),
        .forward_overtravel_out(), .reverse_overtravel_out(),
        .hold_position_error_out(herr), .dynamic_brake_stop_out(brk),
        .decel_stop_out(dec), .coast_out(cst), .zero_clamp_out(zc),
        .stop_torque_out(tqo), .travel_warning_code_out()
    );
    tls_partner u_sw (
        .sys_clk_in(clk), .fwd_trip_in(tf), .rev_trip_in(tr),
        .clr_req_in(creq), .hold_err_in(herr), .fwd_lim_out(fl),
        .rev_lim_out(rl), .clr_out(clr)
    );
    initial forever #25 clk = ~clk;
    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input [31:0] seen, input [31:0] want);
        cmp_count = cmp_count + 1;
        if (seen !== want) begin
            err_count = err_count + 1;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // Request held until waitrequest is sampled low
    task bus(input w, input [3:0] a, input [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (wt !== 1'b0) @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task rdx(input [3:0] a, input [31:0] m, input [31:0] x);
        exp_q.push_back({m, x});
        bus(1'b0, a, 32'h0);
    endtask
    task ot(input f, r, input [1:0] rv, input [31:0] s, input [1:0] ok);
        {rf, rr, tf, tr} <= {rv, f, r};
        tick(10);
        chk({30'h0, fok, rok}, {30'h0, ok});
        rdx(4'hc, 32'hb, s);
        {tf, tr, rf, rr} <= 4'h0;
        tick(HOLD + 10);
    endtask
    // Long settle after each run so warnings never overlap
    task stop_run(input [7:0] c, input [3:0] m, input [3:0] s);
        bus(1'b1, 4'h0, {16'h1, c, 8'h32});
        rs <= 1'b1;
        tick(1);
        rs <= 1'b0;
        {rf, tf} <= 2'h3;
        tick(10);
        chk({28'h0, brk, dec, cst, zc}, {28'h0, m});
        chk({22'h0, tqo}, m[2] ? ((v < 300) ? v : 32'h12c) : 32'h0);
        stp_in <= 1'b1;
        tick(10);
        chk({28'h0, brk, dec, cst, zc}, {28'h0, s});
        {rf, tf, stp_in} <= 3'h0;
        tick(HOLD + 10);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rd === 1'b1 && wt === 1'b0) begin
            e = exp_q.pop_front();
            chk(rdat & e[63:32], e[31:0] & e[63:32]);
        end
        if (cyc == 5000) begin
            err_count = err_count + 1;
            test_done;
        end
    end
    initial begin
        tick(2);
        rst_n <= 1'b1;
        tick(3);
        rdx(4'h0, M, 32'h32);
        rdx(4'h4, M, 32'h320);
        rdx(4'h8, M, 32'h12c);
        rdx(4'h2, M, 32'h0);
        bus(1'b1, 4'h4, 32'h3ff);
        rdx(4'h4, M, 32'h320);
        v = {$random(seed)} % 801;
        bus(1'b1, 4'h4, v);
        rdx(4'h4, M, v);
        bus(1'b1, 4'h0, 32'h10032);
        pwr <= 1'b1;
        tf <= 1'b1;
        tick(8);
        tf <= 1'b0;
        tick(10);
        rdx(4'hc, 32'hb, 32'h8);
        tick(HOLD);
        rdx(4'hc, 32'hb, 32'h0);
        ot(1'b0, 1'b1, 2'h0, 32'ha, 2'h2);
        ot(1'b0, 1'b1, 2'h2, 32'h2, 2'h2);
        ot(1'b1, 1'b0, 2'h2, 32'h9, 2'h1);
        ot(1'b0, 1'b1, 2'h1, 32'ha, 2'h2);
        pwr <= 1'b0;
        ot(1'b1, 1'b0, 2'h0, 32'h1, 2'h1);
        tf <= 1'b1;
        tick(10);
        pwr <= 1'b1;
        tick(10);
        rdx(4'hc, 32'hb, 32'h1);
        tf <= 1'b0;
        tick(10);
        pos <= 1'b1;
        for (i = 0; i < 5; i = i + 1) stop_run(codes[i], mv[i], st[i]);
        chk({31'h0, herr}, 32'h1);
        creq <= 1'b1;
        tick(4);
        creq <= 1'b0;
        chk({31'h0, herr}, 32'h0);
        {pos, tq} <= 2'h1;
        stop_run(8'h10, 4'h8, 4'h2);
        tq <= 1'b0;
        bus(1'b1, 4'h0, 32'h10088);
        ot(1'b1, 1'b1, 2'h0, 32'hb, 2'h0);
        rs <= 1'b1;
        tick(1);
        rs <= 1'b0;
        ot(1'b1, 1'b1, 2'h0, 32'h0, 2'h3);
        test_done;
    end
endmodule

// [dv/tls_partner.sv]
// Purpose: limit switches and host clear line
// Assumes: switch high means travel allowed
// Notes: clear only answered while an error is held
module tls_partner (
    input wire sys_clk_in,
    input wire fwd_trip_in,
    input wire rev_trip_in,
    input wire clr_req_in,
    input wire hold_err_in,
    output reg fwd_lim_out = 1'b1,
    output reg rev_lim_out = 1'b1,
    output reg clr_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge sys_clk_in) begin
        fwd_lim_out <= !fwd_trip_in;
        rev_lim_out <= !rev_trip_in;
        clr_out <= clr_req_in && hold_err_in;
    end
endmodule

// [dv/tls_properties.sv]
// Purpose: port assertions for the travel limit supervisor
// Assumes: one clock domain, reset active low
// Notes: hold check skips drops caused by power going off
module tls_properties #(
    parameter HOLD_CYCLES = 50
) (
    input wire sys_clk_in,
    input wire arst_n_in,
    input wire motor_power_on_in,
    input wire torque_control_in,
    input wire error_clear_input_in,
    input wire forward_allowed_out,
    input wire reverse_allowed_out,
    input wire forward_overtravel_out,
    input wire reverse_overtravel_out,
    input wire hold_position_error_out,
    input wire decel_stop_out,
    input wire zero_clamp_out,
    input wire [9:0] stop_torque_out,
    input wire travel_warning_code_out
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [31:0] hi_r;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    // Length of the current warning
    always @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in)
            hi_r <= 32'h0;
        else
            hi_r <= travel_warning_code_out ? hi_r + 32'h1 : 32'h0;
    end
    sequence s_off2; !motor_power_on_in ##1 !motor_power_on_in; endsequence
    sequence s_tq3; torque_control_in [*3]; endsequence
    sequence s_nodec2; !decel_stop_out ##1 !decel_stop_out; endsequence
    property p_off; s_off2 |-> !travel_warning_code_out; endproperty
    a_off: assert property (p_off) else $error("warn power off");
    property p_hold;
        $fell(travel_warning_code_out) && $past(motor_power_on_in)
            |-> hi_r >= HOLD_CYCLES;
    endproperty
    a_hold: assert property (p_hold) else $error("warn short");
    property p_fwd; forward_overtravel_out |-> !forward_allowed_out; endproperty
    a_fwd: assert property (p_fwd) else $error("fwd open");
    property p_rev; reverse_overtravel_out |-> !reverse_allowed_out; endproperty
    a_rev: assert property (p_rev) else $error("rev open");
    property p_tq; s_tq3 |-> !decel_stop_out && !zero_clamp_out; endproperty
    a_tq: assert property (p_tq) else $error("torque decel");
    property p_cap; stop_torque_out <= 10'h320; endproperty
    a_cap: assert property (p_cap) else $error("torque high");
    property p_idle; s_nodec2 |-> stop_torque_out == 10'h000; endproperty
    a_idle: assert property (p_idle) else $error("torque idle");
    property p_keep;
        hold_position_error_out && !error_clear_input_in
            |=> hold_position_error_out;
    endproperty
    a_keep: assert property (p_keep) else $error("error lost");
    property p_clr; error_clear_input_in |=> !hold_position_error_out; endproperty
    a_clr: assert property (p_clr) else $error("error kept");
endmodule

bind travel_limit_supervisor tls_properties #(
    .HOLD_CYCLES(HOLD_CYCLES)
) u_props (
    .sys_clk_in, .arst_n_in, .motor_power_on_in, .torque_control_in,
    .error_clear_input_in, .forward_allowed_out, .reverse_allowed_out,
    .forward_overtravel_out, .reverse_overtravel_out,
    .hold_position_error_out, .decel_stop_out, .zero_clamp_out,
    .stop_torque_out, .travel_warning_code_out
);

// [include/travel_limit_supervisor_regs.vh]
// Purpose: constants for the travel limit supervisor
// Assumes: 20 MHz system clock
// Notes: setting codes kept as numeric digit values
`ifndef TRAVEL_LIMIT_SUPERVISOR_REGS_VH
`define TRAVEL_LIMIT_SUPERVISOR_REGS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_CONFIG 4'h0
`define OFS_ESTOP_TORQUE 4'h4
`define OFS_MAX_TORQUE 4'h8
`define OFS_STATUS 4'hc

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define CFG_FWD_LO 0
`define CFG_FWD_HI 3
`define CFG_REV_LO 4
`define CFG_REV_HI 7
`define CFG_STOP_LO 8
`define CFG_STOP_HI 15
`define CFG_WARN_BIT 16

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define FWD_ASSIGN_INPUT 4'h2
`define FWD_ASSIGN_OFF 4'h8
`define REV_ASSIGN_INPUT 4'h3
`define REV_ASSIGN_OFF 4'h8
`define STOP_BRAKE_COAST 8'h00
`define STOP_BRAKE_COAST_B 8'h01
`define STOP_COAST 8'h02
`define STOP_DEC_CLAMP 8'h10
`define STOP_DEC_COAST 8'h20
`define ESTOP_TORQUE_RESET 10'h320
`define ESTOP_TORQUE_MAX 10'h320
`define MAX_TORQUE_RESET 10'h12c

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 20000000
`define WARN_HOLD_MS 1000
`define WARN_HOLD_CYCLES (`CLK_HZ / 1000 * `WARN_HOLD_MS)

`endif

// [verilog/travel_limit_supervisor.v]
// Purpose: limit switch supervision, stop selection, travel warning
// Assumes: Avalon-MM slave, one wait state on every access
// Notes: settings marked restart are latched on restart_in pulses
//
// Function
// - Forward limit input off blocks forward travel, flags forward overtravel.
// - Reverse limit input off blocks reverse travel, flags reverse overtravel.
// - Motion away from a tripped limit is still allowed.
// - Position error held on overtravel stop in position control until error clear input.
// - Forward limit can be ignored by setting, applied at restart.
// - Reverse setting 3 uses input, 8 disables; applied at restart.
// - Stop method selects dynamic brake, coast, decel clamp or decel coast.
// - Zero clamp mode holds position reference zero after stopping.
// - Torque control never decelerates; brake or coast, then coast.
// - Emergency stop torque 0 to 800 percent, default 800, immediate.
// - Applied stop torque clamped to motor maximum torque.
// - Warning raised on overtravel with power on when enabled.
// - Momentary limit trip still captured as a warning.
// - Warning for trip on same side as reference direction.
// - No warning for trip opposite to reference direction.
// - With no reference, either side trip raises the warning.
// - No warning while motor power is off.
// - Existing overtravel at power on raises no warning.
// - Warning held one second after overtravel ends, then cleared.
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`include "travel_limit_supervisor_regs.vh"

module travel_limit_supervisor #(
    parameter HOLD_CYCLES = `WARN_HOLD_CYCLES
) (
    input wire sys_clk_in,
    input wire arst_n_in,
    input wire restart_in,
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    input wire forward_limit_input_in,
    input wire reverse_limit_input_in,
    input wire error_clear_input_in,
    input wire motor_power_on_in,
    input wire torque_control_in,
    input wire position_control_in,
    input wire ref_forward_in,
    input wire ref_reverse_in,
    input wire motor_stopped_in,
    output reg forward_allowed_out,
    output reg reverse_allowed_out,
    output reg forward_overtravel_out,
    output reg reverse_overtravel_out,
    output reg hold_position_error_out,
    output reg dynamic_brake_stop_out,
    output reg decel_stop_out,
    output reg coast_out,
    output reg zero_clamp_out,
    output reg [9:0] stop_torque_out,
    output reg travel_warning_code_out
);

// ----------------------------------------
// Reset release
// ----------------------------------------
reg [1:0] rst_sync_r;
wire rst_n = rst_sync_r[1];
always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
        rst_sync_r <= 2'b00;
    else
        rst_sync_r <= {rst_sync_r[0], 1'b1};
end

// ----------------------------------------
// Limit input synchronisers
// ----------------------------------------
reg [2:0] fwd_sync_r;
reg [2:0] rev_sync_r;
reg fwd_on_r;
reg rev_on_r;
always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        fwd_sync_r <= 3'b111;
        fwd_on_r <= 1'b1;
    end else begin
        fwd_sync_r <= {fwd_sync_r[1:0], forward_limit_input_in};
        // Change counts only when stages two and three agree
        if (fwd_sync_r[1] == fwd_sync_r[2])
            fwd_on_r <= fwd_sync_r[2];
    end
end

always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        rev_sync_r <= 3'b111;
        rev_on_r <= 1'b1;
    end else begin
        rev_sync_r <= {rev_sync_r[1:0], reverse_limit_input_in};
        // Same filter as the forward side
        if (rev_sync_r[1] == rev_sync_r[2])
            rev_on_r <= rev_sync_r[2];
    end
end

// ----------------------------------------
// Register file
// ----------------------------------------
reg [3:0] fwd_assign_r;
reg [3:0] rev_assign_r;
reg [7:0] stop_sel_r;
reg warn_en_r;
reg [9:0] estop_torque_r;
reg [9:0] max_torque_r;
// Restart-applied copies
reg [3:0] fwd_assign_act_r;
reg [3:0] rev_assign_act_r;
reg [7:0] stop_sel_act_r;
reg ack_r;
wire access = (avs_read_in | avs_write_in) & ~ack_r;
assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
wire wr_go = avs_write_in & ack_r;
wire rd_go = avs_read_in & ~ack_r;

always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        ack_r <= 1'b0;
        fwd_assign_r <= `FWD_ASSIGN_INPUT;
        rev_assign_r <= `REV_ASSIGN_INPUT;
        stop_sel_r <= `STOP_BRAKE_COAST;
        warn_en_r <= 1'b0;
        estop_torque_r <= `ESTOP_TORQUE_RESET;
        max_torque_r <= `MAX_TORQUE_RESET;
        fwd_assign_act_r <= `FWD_ASSIGN_INPUT;
        rev_assign_act_r <= `REV_ASSIGN_INPUT;
        stop_sel_act_r <= `STOP_BRAKE_COAST;
    end else begin
        ack_r <= access;
        if (wr_go) begin
            case (avs_address_in)
            `OFS_CONFIG: begin
                fwd_assign_r <= avs_writedata_in[`CFG_FWD_HI:`CFG_FWD_LO];
                rev_assign_r <= avs_writedata_in[`CFG_REV_HI:`CFG_REV_LO];
                stop_sel_r <= avs_writedata_in[`CFG_STOP_HI:`CFG_STOP_LO];
                warn_en_r <= avs_writedata_in[`CFG_WARN_BIT];
            end
            `OFS_ESTOP_TORQUE: begin
                // Out of range writes saturate at the top setting
                if (avs_writedata_in[9:0] > `ESTOP_TORQUE_MAX ||
                    avs_writedata_in[31:10] != 22'h000000)
                    estop_torque_r <= `ESTOP_TORQUE_MAX;
                else
                    estop_torque_r <= avs_writedata_in[9:0];
            end
            `OFS_MAX_TORQUE: max_torque_r <= avs_writedata_in[9:0];
            default: ;
            endcase
        end
        if (restart_in) begin
            fwd_assign_act_r <= fwd_assign_r;
            rev_assign_act_r <= rev_assign_r;
            stop_sel_act_r <= stop_sel_r;
        end
    end
end

// ----------------------------------------
// Limit decode
// ----------------------------------------
// Any code other than off takes the pin, so a typo never disables a limit
wire fwd_trip = (fwd_assign_act_r != `FWD_ASSIGN_OFF) & ~fwd_on_r;
wire rev_trip = (rev_assign_act_r != `REV_ASSIGN_OFF) & ~rev_on_r;
wire any_trip = fwd_trip | rev_trip;
wire moving_into = (fwd_trip & ref_forward_in) | (rev_trip & ref_reverse_in);

// ----------------------------------------
// Stop method decode
// ----------------------------------------
reg sel_brake;
reg sel_dec;
reg sel_clamp;
always @* begin
    sel_brake = 1'b0;
    sel_dec = 1'b0;
    sel_clamp = 1'b0;
    case (stop_sel_act_r)
    `STOP_BRAKE_COAST, `STOP_BRAKE_COAST_B: sel_brake = 1'b1;
    `STOP_COAST: sel_brake = 1'b0;
    `STOP_DEC_CLAMP: begin
        sel_dec = 1'b1;
        sel_clamp = 1'b1;
    end
    `STOP_DEC_COAST: sel_dec = 1'b1;
    default: sel_brake = 1'b1;
    endcase
    if (torque_control_in) begin
        // Low digit picks brake or coast under torque control
        sel_dec = 1'b0;
        sel_clamp = 1'b0;
        sel_brake = (stop_sel_act_r[3:0] != 4'h2);
    end
end

// ----------------------------------------
// Stop sequencing
// ----------------------------------------
localparam ST_RUN = 3'b001;
localparam ST_STOPPING = 3'b010;
localparam ST_STOPPED = 3'b100;
reg [2:0] state_r;
reg [2:0] state_nxt;
always @* begin
    state_nxt = state_r;
    case (state_r)
    ST_RUN:
        if (moving_into)
            state_nxt = ST_STOPPING;
    ST_STOPPING:
        if (motor_stopped_in)
            state_nxt = ST_STOPPED;
    ST_STOPPED:
        if (!any_trip)
            state_nxt = ST_RUN;
    default: state_nxt = ST_RUN;
    endcase
    // Reversing away hands control back to the reference
    if (!moving_into && state_r == ST_STOPPING)
        state_nxt = ST_RUN;
end

wire [9:0] torque_lim = (estop_torque_r > max_torque_r) ?
    max_torque_r : estop_torque_r;

// ----------------------------------------
// Output next values
// ----------------------------------------
// Outputs registered so pins never glitch on decode changes
reg forward_allowed_nxt;
reg reverse_allowed_nxt;
reg forward_overtravel_nxt;
reg reverse_overtravel_nxt;
reg hold_error_nxt;
reg brake_stop_nxt;
reg decel_stop_nxt;
reg coast_nxt;
reg zero_clamp_nxt;
reg [9:0] stop_torque_nxt;
wire stopping_nxt = (state_nxt == ST_STOPPING);
wire stopped_nxt = (state_nxt == ST_STOPPED);
always @* begin
    forward_allowed_nxt = ~fwd_trip;
    reverse_allowed_nxt = ~rev_trip;
    forward_overtravel_nxt = fwd_trip;
    reverse_overtravel_nxt = rev_trip;
    hold_error_nxt = hold_position_error_out;
    // Clear wins over a new stop in the same cycle
    if (error_clear_input_in)
        hold_error_nxt = 1'b0;
    else if (position_control_in && stopping_nxt)
        hold_error_nxt = 1'b1;
    brake_stop_nxt = stopping_nxt & sel_brake;
    decel_stop_nxt = stopping_nxt & sel_dec;
    coast_nxt = 1'b0;
    if (stopping_nxt && !sel_brake && !sel_dec)
        coast_nxt = 1'b1;
    if (stopped_nxt && !sel_clamp)
        coast_nxt = 1'b1;
    zero_clamp_nxt = stopped_nxt & sel_clamp;
    stop_torque_nxt = 10'h000;
    if (stopping_nxt && sel_dec)
        stop_torque_nxt = torque_lim;
end

always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        state_r <= ST_RUN;
        forward_allowed_out <= 1'b1;
        reverse_allowed_out <= 1'b1;
        forward_overtravel_out <= 1'b0;
        reverse_overtravel_out <= 1'b0;
        hold_position_error_out <= 1'b0;
        dynamic_brake_stop_out <= 1'b0;
        decel_stop_out <= 1'b0;
        coast_out <= 1'b0;
        zero_clamp_out <= 1'b0;
        stop_torque_out <= 10'h000;
    end else begin
        state_r <= state_nxt;
        forward_allowed_out <= forward_allowed_nxt;
        reverse_allowed_out <= reverse_allowed_nxt;
        forward_overtravel_out <= forward_overtravel_nxt;
        reverse_overtravel_out <= reverse_overtravel_nxt;
        hold_position_error_out <= hold_error_nxt;
        dynamic_brake_stop_out <= brake_stop_nxt;
        decel_stop_out <= decel_stop_nxt;
        coast_out <= coast_nxt;
        zero_clamp_out <= zero_clamp_nxt;
        stop_torque_out <= stop_torque_nxt;
    end
end

// ----------------------------------------
// Travel warning
// ----------------------------------------
reg power_d_r;
reg [31:0] hold_cnt_r;
// Trip present when power came on is masked until it clears
reg masked_r;
wire same_fwd = ref_forward_in & fwd_trip;
wire same_rev = ref_reverse_in & rev_trip;
wire no_ref = ~ref_forward_in & ~ref_reverse_in;
wire idle_trip = no_ref & any_trip;
wire dir_trip = same_fwd | same_rev | idle_trip;
wire power_rise = motor_power_on_in & ~power_d_r;
wire warn_event = warn_en_r & motor_power_on_in & ~power_rise &
    ~masked_r & dir_trip;
always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
        power_d_r <= 1'b0;
        masked_r <= 1'b0;
        hold_cnt_r <= 32'h00000000;
        travel_warning_code_out <= 1'b0;
    end else begin
        power_d_r <= motor_power_on_in;
        if (!motor_power_on_in || !any_trip)
            masked_r <= 1'b0;
        else if (power_rise)
            masked_r <= 1'b1;
        if (!motor_power_on_in) begin
            travel_warning_code_out <= 1'b0;
            hold_cnt_r <= 32'h00000000;
        end else if (warn_event) begin
            travel_warning_code_out <= 1'b1;
            hold_cnt_r <= HOLD_CYCLES;
        end else if (hold_cnt_r != 32'h00000000) begin
            hold_cnt_r <= hold_cnt_r - 32'h00000001;
            if (hold_cnt_r == 32'h00000001)
                travel_warning_code_out <= 1'b0;
        end
    end
end

// ----------------------------------------
// Read data
// ----------------------------------------
always @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n)
        avs_readdata_out <= 32'h00000000;
    else if (rd_go) begin
        case (avs_address_in)
        `OFS_CONFIG: begin
            avs_readdata_out <= {15'h0000, warn_en_r,
                stop_sel_r, rev_assign_r, fwd_assign_r};
        end
        `OFS_ESTOP_TORQUE: begin
            avs_readdata_out <= {22'h000000, estop_torque_r};
        end
        `OFS_MAX_TORQUE: begin
            avs_readdata_out <= {22'h000000, max_torque_r};
        end
        `OFS_STATUS: begin
            avs_readdata_out <= {24'h000000, 1'b0, state_r,
                travel_warning_code_out, hold_position_error_out,
                reverse_overtravel_out, forward_overtravel_out};
        end
        default: begin
            avs_readdata_out <= 32'h00000000;
        end
        endcase
    end
end

endmodule
